// ---- src/pls_pkg.sv ----
// constants of the limits, status and telemetry command bank
package pls_pkg;

  localparam int NUM_LIMITS = 11;
  localparam int IDX_W      = 4;

  localparam int IDX_TURN_ON   = 0;
  localparam int IDX_TURN_OFF  = 1;
  localparam int IDX_VOUT_OVF  = 2;
  localparam int IDX_VOUT_OVW  = 3;
  localparam int IDX_IOUT_OCF  = 4;
  localparam int IDX_IOUT_OCW  = 5;
  localparam int IDX_OT_FAULT  = 6;
  localparam int IDX_OT_WARN   = 7;
  localparam int IDX_VIN_OVF   = 8;
  localparam int IDX_ON_DELAY  = 9;
  localparam int IDX_ON_RISE   = 10;

  // writable limit words, in index order
  localparam logic [7:0] LIM_CODE [0:NUM_LIMITS-1] = '{
    8'h35, 8'h36, 8'h40, 8'h42, 8'h46, 8'h4a, 8'h4f, 8'h51, 8'h55, 8'h60, 8'h61};
  // fixed exponent per command, 5-bit two's complement
  localparam logic signed [4:0] LIM_EXP [0:NUM_LIMITS-1] = '{
    5'sh1f, 5'sh1f, 5'sh17, 5'sh17, 5'sh1c, 5'sh1c, 5'sh1e, 5'sh1e, 5'sh1f, 5'sh1f, 5'sh1f};
  // output-voltage words carry a plain unsigned mantissa
  localparam logic LIM_IS_VOUT [0:NUM_LIMITS-1] = '{
    1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  // range bounds as mantissas at the fixed exponent
  localparam logic [15:0] LIM_MIN [0:NUM_LIMITS-1] = '{
    16'h03ac, 16'h0398, 16'h7800, 16'h7400, 16'h01c0, 16'h01a0,
    16'h01b8, 16'h0190, 16'h0654, 16'h0028, 16'h0096};
  localparam logic [15:0] LIM_MAX [0:NUM_LIMITS-1] = '{
    16'h03c0, 16'h03ac, 16'h7c00, 16'h7c00, 16'h0200, 16'h0200,
    16'h021c, 16'h0208, 16'h067c, 16'h00c8, 16'h03e8};
  // reset words; 820 V cannot fit an 11-bit mantissa at -1, so exponent 0
  localparam logic [15:0] LIM_RST [0:NUM_LIMITS-1] = '{
    16'hfbac, 16'hfb98, 16'h7800, 16'h7400, 16'he200, 16'he1e0,
    16'hf1f4, 16'hf190, 16'h0334, 16'hf828, 16'hf896};

  localparam logic [7:0] CMD_SUMMARY   = 8'h79;
  localparam logic [7:0] CMD_VOUT_ST   = 8'h7a;
  localparam logic [7:0] CMD_IOUT_ST   = 8'h7b;
  localparam logic [7:0] CMD_INPUT_ST  = 8'h7c;
  localparam logic [7:0] CMD_TEMP_ST   = 8'h7d;
  localparam logic [7:0] CMD_COMM_ST   = 8'h7e;
  localparam logic [7:0] CMD_RD_VIN    = 8'h88;
  localparam logic [7:0] CMD_RD_VOUT   = 8'h8b;
  localparam logic [7:0] CMD_RD_IOUT   = 8'h8c;
  localparam logic [7:0] CMD_READ_TEMP = 8'h8d;
  localparam logic [7:0] CMD_REVISION  = 8'h98;
  localparam logic [7:0] CMD_FLASH_KEY = 8'hec;

  localparam logic [31:0] FLASH_KEY_RST   = 32'ha5a5a5a5;
  localparam logic [31:0] FLASH_KEY_VALUE = 32'h7e15dc42;

  localparam int COMM_BAD_CMD  = 7;
  localparam int COMM_BAD_DATA = 6;
  localparam int ST_FAULT_BIT  = 7;

  localparam int SUM_VOUT   = 15;
  localparam int SUM_IOUT   = 14;
  localparam int SUM_INPUT  = 13;
  localparam int SUM_PGOOD  = 11;
  localparam int SUM_OFF    = 6;
  localparam int SUM_OV     = 5;
  localparam int SUM_OC     = 4;
  localparam int SUM_UV     = 3;
  localparam int SUM_TEMP   = 2;
  localparam int SUM_COMM   = 1;

  typedef struct packed {
    logic [NUM_LIMITS-1:0][15:0] lim;
    logic [31:0]                 key;
    logic [7:0]                  comm;
    logic                        rsp_valid;
    logic                        rsp_error;
    logic [31:0]                 rsp_data;
  } pls_state_t;

endpackage

// ---- src/pls_bank.sv ----
// command-coded limit, status and telemetry bank of the power module
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RL1 - 0x35 holds turn-on threshold, exponent -1, default 470 V, range 470..480 V.
// RL2 - host keeps turn-off threshold 0x36 (460..470 V) below turn-on threshold.
// RL3 - host keeps OV fault 0x40 (60..62 V, exp -9) above setpoint and warn.
// RL4 - host keeps OV warning 0x42 (58..62 V, exp -9) at or below fault.
// RL5 - host keeps OC fault 0x46 (28..32 A, exp -4) above OC warning.
// RL6 - 0x4a holds OC warning, exponent -4, default 30 A, range 26..32 A.
// RL7 - host keeps OT fault 0x4f (110..135 C, exp -2) above OT warning.
// RL8 - 0x51 holds temperature warning, exponent -2, default 100 C, range 100..130.
// RL9 - 0x55 holds input OV fault, exponent -1, default 820 V, range 810..830.
// RL10 - 0x60 holds start-to-rise delay, exponent -1, default 20 ms, range 20..100.
// RL11 - 0x61 holds rise-to-regulation time, exponent -1, default 75 ms, range 75..500.
// RL12 - 0x79 reads a summary word of all faults and warnings.
// RL13 - 0x7a reads the output voltage status byte.
// RL14 - 0x7b reads the output current status byte.
// RL15 - 0x7c reads the input over/under-voltage status byte.
// RL16 - 0x7d reads the temperature status byte.
// RL17 - 0x7e reads the communication fault byte.
// RL18 - 0x88 reads measured input voltage, exponent -1.
// RL19 - 0x8b reads measured output voltage, exponent -9.
// RL20 - 0x8c reads measured output current, exponent -4.
// RL21 - 0x8d reads hot-spot temperature, exponent -2.
// RL22 - flash unlocks only after key block 7e,15,dc,42 is written to 0xec.
// RL23 - output voltage words are unsigned 16-bit mantissas at exponent -9.
// RL24 - other words: 5-bit signed exponent over 11-bit signed mantissa.
// RL25 - out-of-range write is dropped, old value kept, communication fault raised.
module pls_bank #(
  parameter logic [7:0] REVISION = 8'h01  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [31:0] cmd_wdata,
  output logic             rsp_valid,
  output logic             rsp_error,
  output logic [31:0]      rsp_data,
  input  wire logic        clear_faults,
  input  wire logic        store_done,
  input  wire logic [7:0]  vout_status_in,
  input  wire logic [7:0]  iout_status_in,
  input  wire logic [7:0]  input_status_in,
  input  wire logic [7:0]  temp_status_in,
  input  wire logic        power_good_n,
  input  wire logic        unit_off,
  input  wire logic        vin_uv_fault,
  input  wire logic [15:0] vin_reading_in,
  input  wire logic [15:0] vout_reading_in,
  input  wire logic [15:0] iout_reading_in,
  input  wire logic [15:0] temp_reading_in,
  output logic [15:0]      input_turn_on_threshold,
  output logic [15:0]      input_turn_off_threshold,
  output logic [15:0]      output_overvoltage_fault_limit,
  output logic [15:0]      output_overvoltage_warn_limit,
  output logic [15:0]      output_overcurrent_fault_limit,
  output logic [15:0]      output_overcurrent_warn_limit,
  output logic [15:0]      overtemp_fault_limit,
  output logic [15:0]      overtemp_warn_limit,
  output logic [15:0]      input_overvoltage_fault_limit,
  output logic [15:0]      turn_on_delay_time,
  output logic [15:0]      turn_on_rise_time,
  output logic             flash_unlocked
);

  ////////////////////////////////////////////////////////////////////////////
  // linear-format range check

  // the word may use any exponent; it is rescaled to the fixed one and must be exact
  function automatic logic pls_in_range(input logic [15:0]       w,
                                        input logic signed [4:0] fe,
                                        input logic              is_vout,
                                        input logic [15:0]       lo,
                                        input logic [15:0]       hi);
    logic signed [5:0]  d;
    logic signed [5:0]  nd;
    logic signed [39:0] m;
    logic signed [39:0] v;
    logic signed [39:0] vlo;
    logic signed [39:0] vhi;
    logic               exact;
    d     = {w[15], w[15:11]} - {fe[4], fe};
    nd    = -d;
    m     = {{29{w[10]}}, w[10:0]};
    vlo   = {24'h000000, lo};
    vhi   = {24'h000000, hi};
    exact = 1'b1;
    if (d >= 0) begin
      v = m <<< d[4:0];
    end else begin
      v     = m >>> nd[4:0];
      exact = ((v <<< nd[4:0]) == m);
    end
    if (is_vout) begin
      return (w >= lo) && (w <= hi);  // RL23
    end
    return exact && (v >= vlo) && (v <= vhi);  // RL24
  endfunction

  // a word given at another exponent is stored at the fixed one, so readers see one scale;
  // a value whose mantissa cannot fit there (input OV limit) keeps its own exponent
  function automatic logic [15:0] pls_rescale(input logic [15:0]       w,
                                              input logic signed [4:0] fe,
                                              input logic              is_vout);
    logic signed [5:0]  d;
    logic signed [5:0]  nd;
    logic signed [39:0] m;
    logic signed [39:0] v;
    d  = {w[15], w[15:11]} - {fe[4], fe};
    nd = -d;
    m  = {{29{w[10]}}, w[10:0]};
    if (d >= 0) begin
      v = m <<< d[4:0];
    end else begin
      v = m >>> nd[4:0];
    end
    if (is_vout || (v < -40'sd1024) || (v > 40'sd1023)) begin
      return w;
    end
    return {fe, v[10:0]};  // RL24
  endfunction

  pls_pkg::pls_state_t st;
  pls_pkg::pls_state_t next_st;

  logic [pls_pkg::NUM_LIMITS-1:0] lim_sel;
  logic [pls_pkg::NUM_LIMITS-1:0] lim_ok;
  logic [pls_pkg::NUM_LIMITS-1:0][15:0] lim_word;
  logic [15:0]                    summary;
  logic                           wr;
  logic                           rd;

  assign wr = cmd_valid && cmd_write;
  assign rd = cmd_valid && !cmd_write;

  if (pls_pkg::NUM_LIMITS > (1 << pls_pkg::IDX_W)) begin : g_chk
    $error("pls_bank: limit index too narrow");
  end

  for (genvar i = 0; i < pls_pkg::NUM_LIMITS; i++) begin : g_lim
    assign lim_sel[i] = (cmd_code == pls_pkg::LIM_CODE[i]);
    assign lim_ok[i]  = pls_in_range(cmd_wdata[15:0], pls_pkg::LIM_EXP[i],
                                     pls_pkg::LIM_IS_VOUT[i], pls_pkg::LIM_MIN[i],
                                     pls_pkg::LIM_MAX[i]);  // RL1 RL6 RL8 RL9 RL10 RL11
    assign lim_word[i] = pls_rescale(cmd_wdata[15:0], pls_pkg::LIM_EXP[i],
                                     pls_pkg::LIM_IS_VOUT[i]);  // RL24
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary word, built live from the protection inputs and the communication fault byte

  always_comb begin
    summary                    = 16'h0000;
    summary[pls_pkg::SUM_VOUT]  = |vout_status_in;  // RL12
    summary[pls_pkg::SUM_IOUT]  = |iout_status_in;
    summary[pls_pkg::SUM_INPUT] = |input_status_in;
    summary[pls_pkg::SUM_PGOOD] = power_good_n;
    summary[pls_pkg::SUM_OFF]   = unit_off;
    summary[pls_pkg::SUM_OV]    = vout_status_in[pls_pkg::ST_FAULT_BIT];
    summary[pls_pkg::SUM_OC]    = iout_status_in[pls_pkg::ST_FAULT_BIT];
    summary[pls_pkg::SUM_UV]    = vin_uv_fault;
    summary[pls_pkg::SUM_TEMP]  = |temp_status_in;
    summary[pls_pkg::SUM_COMM]  = |st.comm;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and state update

  always_comb begin
    logic [31:0] rdata;
    logic        known;
    logic        hit;
    logic [pls_pkg::IDX_W-1:0] idx;
    rdata = 32'h00000000;
    known = 1'b1;
    hit   = 1'b0;
    idx   = '0;
    for (int i = 0; i < pls_pkg::NUM_LIMITS; i++) begin
      if (lim_sel[i]) begin
        hit = 1'b1;
        idx = pls_pkg::IDX_W'(i);
      end
    end

    if (hit) begin
      rdata = {16'h0000, st.lim[idx]};
    end else if (cmd_code == pls_pkg::CMD_SUMMARY) begin
      rdata = {16'h0000, summary};  // RL12
    end else if (cmd_code == pls_pkg::CMD_VOUT_ST) begin
      rdata = {24'h000000, vout_status_in};  // RL13
    end else if (cmd_code == pls_pkg::CMD_IOUT_ST) begin
      rdata = {24'h000000, iout_status_in};  // RL14
    end else if (cmd_code == pls_pkg::CMD_INPUT_ST) begin
      rdata = {24'h000000, input_status_in};  // RL15
    end else if (cmd_code == pls_pkg::CMD_TEMP_ST) begin
      rdata = {24'h000000, temp_status_in};  // RL16
    end else if (cmd_code == pls_pkg::CMD_COMM_ST) begin
      rdata = {24'h000000, st.comm};  // RL17
    end else if (cmd_code == pls_pkg::CMD_RD_VIN) begin
      rdata = {16'h0000, vin_reading_in};  // RL18
    end else if (cmd_code == pls_pkg::CMD_RD_VOUT) begin
      rdata = {16'h0000, vout_reading_in};  // RL19
    end else if (cmd_code == pls_pkg::CMD_RD_IOUT) begin
      rdata = {16'h0000, iout_reading_in};  // RL20
    end else if (cmd_code == pls_pkg::CMD_READ_TEMP) begin
      rdata = {16'h0000, temp_reading_in};  // RL21
    end else if (cmd_code == pls_pkg::CMD_REVISION) begin
      rdata = {24'h000000, REVISION};
    end else if (cmd_code == pls_pkg::CMD_FLASH_KEY) begin
      rdata = st.key;
    end else begin
      known = 1'b0;
    end

    next_st           = st;
    next_st.rsp_valid = cmd_valid;
    next_st.rsp_error = 1'b0;
    if (rd) begin
      next_st.rsp_data = rdata;
    end else if (wr) begin
      next_st.rsp_data = 32'h00000000;
    end

    // clear first so that a fault in the same cycle survives
    if (clear_faults) begin
      next_st.comm = 8'h00;
    end
    // a finished store locks the flash again
    if (store_done) begin
      next_st.key = pls_pkg::FLASH_KEY_RST;
    end

    if (wr && hit) begin
      if (lim_ok[idx]) begin
        next_st.lim[idx] = lim_word[idx];  // RL1 RL24
      end else begin
        next_st.comm[pls_pkg::COMM_BAD_DATA] = 1'b1;  // RL25
        next_st.rsp_error                    = 1'b1;
      end
    end else if (wr && cmd_code == pls_pkg::CMD_FLASH_KEY) begin
      next_st.key = cmd_wdata;  // RL22
    end else if (cmd_valid && (wr || !known)) begin
      // read-only or unmapped code
      next_st.comm[pls_pkg::COMM_BAD_CMD] = 1'b1;
      next_st.rsp_error                   = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < pls_pkg::NUM_LIMITS; i++) begin
        st.lim[i] <= pls_pkg::LIM_RST[i];  // RL1 RL6 RL8 RL9 RL10 RL11
      end
      st.key       <= pls_pkg::FLASH_KEY_RST;
      st.comm      <= 8'h00;
      st.rsp_valid <= 1'b0;
      st.rsp_error <= 1'b0;
      st.rsp_data  <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rsp_valid                      = st.rsp_valid;
  assign rsp_error                      = st.rsp_error;
  assign rsp_data                       = st.rsp_data;
  assign input_turn_on_threshold        = st.lim[pls_pkg::IDX_TURN_ON];
  assign input_turn_off_threshold       = st.lim[pls_pkg::IDX_TURN_OFF];
  assign output_overvoltage_fault_limit = st.lim[pls_pkg::IDX_VOUT_OVF];
  assign output_overvoltage_warn_limit  = st.lim[pls_pkg::IDX_VOUT_OVW];
  assign output_overcurrent_fault_limit = st.lim[pls_pkg::IDX_IOUT_OCF];
  assign output_overcurrent_warn_limit  = st.lim[pls_pkg::IDX_IOUT_OCW];
  assign overtemp_fault_limit           = st.lim[pls_pkg::IDX_OT_FAULT];
  assign overtemp_warn_limit            = st.lim[pls_pkg::IDX_OT_WARN];
  assign input_overvoltage_fault_limit  = st.lim[pls_pkg::IDX_VIN_OVF];
  assign turn_on_delay_time             = st.lim[pls_pkg::IDX_ON_DELAY];
  assign turn_on_rise_time              = st.lim[pls_pkg::IDX_ON_RISE];
  assign flash_unlocked                 = (st.key == pls_pkg::FLASH_KEY_VALUE);  // RL22

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_vin_on_write;
    wr && lim_sel[pls_pkg::IDX_TURN_ON] && lim_ok[pls_pkg::IDX_TURN_ON]
      |=> !rsp_error
          && input_turn_on_threshold[15:11] == pls_pkg::LIM_EXP[pls_pkg::IDX_TURN_ON]
          && ($past(cmd_wdata[15:11]) != input_turn_on_threshold[15:11]
              || input_turn_on_threshold == $past(cmd_wdata[15:0]));
  endproperty
  a_vin_on_write: assert property (p_vin_on_write)  // RL1
    else $error("turn-on threshold not written");

  property p_oc_warn_only_by_write;
    !$stable(output_overcurrent_warn_limit)
      |-> $past(wr && lim_sel[pls_pkg::IDX_IOUT_OCW]);
  endproperty
  a_oc_warn_only_by_write: assert property (p_oc_warn_only_by_write)  // RL6
    else $error("overcurrent warning changed without a write");

  property p_ot_warn_in_range;
    pls_in_range(overtemp_warn_limit, pls_pkg::LIM_EXP[pls_pkg::IDX_OT_WARN], 1'b0,
                 pls_pkg::LIM_MIN[pls_pkg::IDX_OT_WARN],
                 pls_pkg::LIM_MAX[pls_pkg::IDX_OT_WARN]);
  endproperty
  a_ot_warn_in_range: assert property (p_ot_warn_in_range)  // RL8
    else $error("temperature warning outside its range");

  property p_vin_ov_in_range;
    pls_in_range(input_overvoltage_fault_limit, pls_pkg::LIM_EXP[pls_pkg::IDX_VIN_OVF], 1'b0,
                 pls_pkg::LIM_MIN[pls_pkg::IDX_VIN_OVF],
                 pls_pkg::LIM_MAX[pls_pkg::IDX_VIN_OVF]);
  endproperty
  a_vin_ov_in_range: assert property (p_vin_ov_in_range)  // RL9
    else $error("input overvoltage limit outside its range");

  property p_reject_keeps;
    wr && lim_sel[pls_pkg::IDX_ON_DELAY] && !lim_ok[pls_pkg::IDX_ON_DELAY]
      |=> $stable(turn_on_delay_time) && rsp_error && rsp_valid
          && st.comm[pls_pkg::COMM_BAD_DATA];
  endproperty
  a_reject_keeps: assert property (p_reject_keeps)  // RL25
    else $error("rejected write changed the delay or raised no fault");

  property p_fault_set_wins;
    clear_faults && wr && |(lim_sel & ~lim_ok) |=> st.comm[pls_pkg::COMM_BAD_DATA];
  endproperty
  a_fault_set_wins: assert property (p_fault_set_wins)  // RL25
    else $error("fault lost against a clear");

  property p_unlock_needs_key;
    $rose(flash_unlocked)
      |-> $past(wr && cmd_code == pls_pkg::CMD_FLASH_KEY
                && cmd_wdata == pls_pkg::FLASH_KEY_VALUE);
  endproperty
  a_unlock_needs_key: assert property (p_unlock_needs_key)  // RL22
    else $error("flash unlocked without the key");

  property p_read_vin;
    rd && cmd_code == pls_pkg::CMD_RD_VIN
      |=> rsp_valid && !rsp_error && rsp_data == {16'h0000, $past(vin_reading_in)};
  endproperty
  a_read_vin: assert property (p_read_vin)  // RL18
    else $error("input voltage reading wrong");

  property p_summary_comm;
    rd && cmd_code == pls_pkg::CMD_SUMMARY
      |=> rsp_data[pls_pkg::SUM_COMM] == $past(|st.comm) && rsp_data[31:16] == 16'h0000;
  endproperty
  a_summary_comm: assert property (p_summary_comm)  // RL12
    else $error("summary word communication bit wrong");

  property p_comm_read;
    rd && cmd_code == pls_pkg::CMD_COMM_ST
      |=> rsp_valid && !rsp_error && rsp_data == {24'h000000, $past(st.comm)};
  endproperty
  a_comm_read: assert property (p_comm_read)  // RL17
    else $error("communication status read wrong");

  c_reject:  cover property (wr && |(lim_sel & ~lim_ok) ##1 rsp_error);
  c_unlock:  cover property ($rose(flash_unlocked));
  c_rd_back: cover property (wr && lim_sel[pls_pkg::IDX_ON_RISE] ##1
                             rd && lim_sel[pls_pkg::IDX_ON_RISE]);
  c_relock:  cover property (flash_unlocked && store_done ##1 !flash_unlocked);

endmodule // pls_bank

// ---- tb/pls_host.sv ----
// host-side command model for the limit, status and telemetry bank
module pls_host (
  input  wire logic        clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [31:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_error,
  input  wire logic [31:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // released lines carry the inverse, so stale values never pass as live
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [31:0] wd,
                      output logic vld, output logic err, output logic [31:0] rd);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    @(negedge clk);
    vld = rsp_valid;
    err = rsp_error;
    rd = rsp_data;
    cmd_valid = 1'b0;
    cmd_write = ~wr;
    cmd_code = ~code;
    cmd_wdata = ~wd;
  endtask
  // order per pair so the upper limit never dips under the lower one
  task automatic set_pair(input logic up_first, input logic [7:0] uc, input logic [15:0] uw,
                          input logic [7:0] lc, input logic [15:0] lw, output logic bad);
    logic        v0, e0, v1, e1;
    logic [31:0] rd;
    if (up_first) begin
      xfer(1'b1, uc, {16'h0, uw}, v0, e0, rd);
      xfer(1'b1, lc, {16'h0, lw}, v1, e1, rd);
    end else begin
      xfer(1'b1, lc, {16'h0, lw}, v0, e0, rd);
      xfer(1'b1, uc, {16'h0, uw}, v1, e1, rd);
    end
    bad = !(v0 && v1) || e0 || e1;
  endtask
endmodule  // pls_host

// ---- tb/pls_bank_bench.sv ----
// self-checking bench for the limit, status and telemetry bank
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s expected %h seen %h", nm, (e), (g)); end end
module pls_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst, clear_faults, store_done, power_good_n, unit_off, vin_uv_fault;
  logic [7:0]  vout_status_in, iout_status_in, input_status_in, temp_status_in, cmd_code;
  logic [15:0] vin_reading_in, vout_reading_in, iout_reading_in, temp_reading_in;
  logic        cmd_valid, cmd_write, rsp_valid, rsp_error, flash_unlocked, r_vld, r_err, r_bad;
  logic [31:0] cmd_wdata, rsp_data, r_data;
  logic [15:0] lim_out [0:10];
  int          err_count = 0;
  int          samples_checked = 0;
  localparam logic [7:0]  REV = 8'h3c;  // arbitrary value
  localparam logic [15:0] NW [0:10] = '{16'hfbc0, 16'hfbac, 16'h7c00, 16'h7800, 16'he1c0,
    16'he1a0, 16'hf21c, 16'hf208, 16'h032a, 16'hf8c8, 16'hfbe8};
  // one step past a range edge each; KW must survive
  localparam logic [7:0]  BC [0:5] = '{8'h35, 8'h4a, 8'h51, 8'h55, 8'h60, 8'h61};
  localparam logic [15:0] BW [0:5] = '{16'hfbaa, 16'he210, 16'hf18c, 16'h033f, 16'hf826, 16'hfbea};
  localparam logic [15:0] KW [0:5] = '{16'hfbb6, 16'he1a0, 16'hf208, 16'h032a, 16'hf8c8, 16'hfbe8};

  always #50 clk = ~clk;

  pls_host u_host (.clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid,
    .rsp_error, .rsp_data);
  pls_bank #(.REVISION(REV)) u_dut (.clk, .rst, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .rsp_valid, .rsp_error, .rsp_data, .clear_faults, .store_done,
    .vout_status_in, .iout_status_in, .input_status_in, .temp_status_in, .power_good_n,
    .unit_off, .vin_uv_fault, .vin_reading_in, .vout_reading_in, .iout_reading_in,
    .temp_reading_in, .input_turn_on_threshold(lim_out[0]),
    .input_turn_off_threshold(lim_out[1]), .output_overvoltage_fault_limit(lim_out[2]),
    .output_overvoltage_warn_limit(lim_out[3]), .output_overcurrent_fault_limit(lim_out[4]),
    .output_overcurrent_warn_limit(lim_out[5]), .overtemp_fault_limit(lim_out[6]),
    .overtemp_warn_limit(lim_out[7]), .input_overvoltage_fault_limit(lim_out[8]),
    .turn_on_delay_time(lim_out[9]), .turn_on_rise_time(lim_out[10]), .flash_unlocked);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic op(input logic wr, input logic [7:0] code, input logic [31:0] wd);
    u_host.xfer(wr, code, wd, r_vld, r_err, r_data);
    `CHK("answer", 1'b1, r_vld)
    if (wr) `CHK("write data", 32'h0, r_data)
    @(negedge clk);
    `CHK("answer end", 1'b0, rsp_valid)
  endtask

  task automatic t_defaults;
    for (int i = 0; i < 11; i++) begin
      op(1'b0, pls_pkg::LIM_CODE[i], 32'h0);
      `CHK("default", {16'h0, pls_pkg::LIM_RST[i]}, r_data)
      `CHK("default port", pls_pkg::LIM_RST[i], lim_out[i])
    end
    op(1'b0, 8'hec, 32'h0);
    `CHK("key", 32'ha5a5a5a5, r_data)
    `CHK("locked", 1'b0, flash_unlocked)
    $display("defaults test done");
  endtask

  task automatic t_limits;
    u_host.set_pair(1'b1, 8'h35, NW[0], 8'h36, NW[1], r_bad);
    `CHK("on off pair", 1'b0, r_bad)
    u_host.set_pair(1'b1, 8'h40, NW[2], 8'h42, NW[3], r_bad);
    `CHK("ov pair", 1'b0, r_bad)
    u_host.set_pair(1'b0, 8'h46, NW[4], 8'h4a, NW[5], r_bad);
    `CHK("oc pair", 1'b0, r_bad)
    u_host.set_pair(1'b1, 8'h4f, NW[6], 8'h51, NW[7], r_bad);
    `CHK("ot pair", 1'b0, r_bad)
    for (int i = 8; i < 11; i++) begin
      op(1'b1, pls_pkg::LIM_CODE[i], {16'h0, NW[i]});
      `CHK("edge write", 1'b0, r_err)
    end
    for (int i = 0; i < 11; i++) begin
      op(1'b0, pls_pkg::LIM_CODE[i], 32'h0);
      `CHK("readback", {16'h0, NW[i]}, r_data)
      `CHK("limit port", NW[i], lim_out[i])
    end
    // 475 V given at exponent 0 must be held at the fixed exponent
    op(1'b1, 8'h35, 32'h01db);
    op(1'b0, 8'h35, 32'h0);
    `CHK("rescaled", 32'hfbb6, r_data)
    $display("limits test done");
  endtask

  task automatic t_reject;
    for (int i = 0; i < 6; i++) begin
      op(1'b1, BC[i], {16'h0, BW[i]});
      `CHK("range refusal", 1'b1, r_err)
      op(1'b0, BC[i], 32'h0);
      `CHK("kept", {16'h0, KW[i]}, r_data)
    end
    op(1'b0, 8'h7e, 32'h0);
    `CHK("data fault", 32'h40, r_data)
    op(1'b1, 8'h88, 32'h1);
    `CHK("read-only write", 1'b1, r_err)
    op(1'b0, 8'h01, 32'h0);
    `CHK("unknown read", 1'b1, r_err)
    op(1'b0, 8'h7e, 32'h0);
    `CHK("command fault", 32'hc0, r_data)
    op(1'b0, 8'h79, 32'h0);
    `CHK("summary comm", 32'h2, r_data)
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
    op(1'b0, 8'h7e, 32'h0);
    `CHK("cleared", 32'h0, r_data)
    $display("refusal test done");
  endtask

  task automatic t_status(input logic [7:0] vo, io, ip, te, input logic pg, off, uv,
                          input logic [15:0] sum);
    vout_status_in = vo;
    iout_status_in = io;
    input_status_in = ip;
    temp_status_in = te;
    power_good_n = pg;
    unit_off = off;
    vin_uv_fault = uv;
    op(1'b0, 8'h7a, 32'h0);
    `CHK("vout status", {24'h0, vo}, r_data)
    op(1'b0, 8'h7b, 32'h0);
    `CHK("iout status", {24'h0, io}, r_data)
    op(1'b0, 8'h7c, 32'h0);
    `CHK("input status", {24'h0, ip}, r_data)
    op(1'b0, 8'h7d, 32'h0);
    `CHK("temp status", {24'h0, te}, r_data)
    op(1'b0, 8'h79, 32'h0);
    `CHK("summary", {16'h0, sum}, r_data)
    $display("status test done");
  endtask

  task automatic t_telemetry;
    vin_reading_in = 16'hfbc1;
    vout_reading_in = 16'h6c00;
    iout_reading_in = 16'he155;
    temp_reading_in = 16'hf0a3;
    op(1'b0, 8'h88, 32'h0);
    `CHK("vin", 32'hfbc1, r_data)
    op(1'b0, 8'h8b, 32'h0);
    `CHK("vout", 32'h6c00, r_data)
    op(1'b0, 8'h8c, 32'h0);
    `CHK("iout", 32'he155, r_data)
    op(1'b0, 8'h8d, 32'h0);
    `CHK("temp", 32'hf0a3, r_data)
    op(1'b0, 8'h98, 32'h0);
    `CHK("revision", {24'h0, REV}, r_data)
    $display("telemetry test done");
  endtask

  task automatic t_flash;
    op(1'b1, 8'hec, 32'h7e15dc43);
    `CHK("wrong key", 1'b0, flash_unlocked)
    // key block sent whole, first byte in the top lane
    op(1'b1, 8'hec, 32'h7e15dc42);
    `CHK("unlocked", 1'b1, flash_unlocked)
    store_done = 1'b1;
    @(negedge clk);
    store_done = 1'b0;
    `CHK("relocked", 1'b0, flash_unlocked)
    op(1'b0, 8'hec, 32'h0);
    `CHK("key back", 32'ha5a5a5a5, r_data)
    $display("flash test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {rst, clear_faults, store_done, power_good_n, unit_off, vin_uv_fault} = 6'h20;
    {vout_status_in, iout_status_in, input_status_in, temp_status_in} = 32'h0;
    {vin_reading_in, vout_reading_in, iout_reading_in, temp_reading_in} = 64'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_defaults();
    t_limits();
    t_reject();
    t_status(8'h80, 8'h20, 8'h00, 8'h40, 1'b1, 1'b0, 1'b1, 16'hc82c);
    t_status(8'h00, 8'h80, 8'h10, 8'h00, 1'b0, 1'b1, 1'b0, 16'h6050);
    t_telemetry();
    t_flash();
    results();
  end

  // some 72 commands of at most three cycles each
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    results();
  end
endmodule  // pls_bank_bench
